// file: design/dac_loader_regs.svh
// Purpose: offsets, field positions and reset values of the serial loader
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes: definitions only
`ifndef DAC_LOADER_REGS_SVH
`define DAC_LOADER_REGS_SVH

`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define INLATCH_BASE 8'h10
`define CONV_BASE 8'h20
`define CTRL_RESET 32'h0000_0001
`define CTRL_ENABLE_POS 0
`define STATUS_ACCEPT_LSB 0
`define STATUS_REJECT_LSB 8
`define STATUS_OVERRUN_POS 16
`define STATUS_ACTIVE_POS 17
`define WORD_BITS 16
`define CODE_MSB 15
`define CODE_LSB 4
`define ADDR_HI_POS 3
`define ADDR_LO_POS 2
`define LATCH_SEL_HI_POS 1
`define LATCH_SEL_LO_POS 0
`define LAST_BIT_COUNT 4'hf
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: design/dac_loader_pkg.sv
// Purpose: shared types of the serial loader
// Assumes: nothing beyond the header of constants
// Notes: gray-coded frame states
package dac_loader_pkg;
  typedef logic [11:0] code_t;
  typedef logic [1:0] latch_sel_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'h0,
    FRAME_SHIFT = 2'h1,
    FRAME_HOLD = 2'h3
  } frame_state_t;
endpackage : dac_loader_pkg

// file: design/latch_word_if.sv
// Purpose: valid/ready carrier of one accepted word (code and latch select)
// Assumes: single clock domain
// Notes: src drives the word, snk drives ready
`timescale 1ns/1ps
interface latch_word_if
  import dac_loader_pkg::*;
  ();
  logic valid;
  logic ready;
  code_t code;
  latch_sel_t sel;
  modport src (output valid, output code, output sel, input ready);
  modport snk (input valid, input code, input sel, output ready);
endinterface : latch_word_if

// file: design/word_buffer.sv
// Purpose: two-entry buffer between word acceptance and the input latches
// Assumes: one clock, synchronous active-low reset
// Notes: full and empty are exact; ready drops only when both entries hold
`timescale 1ns/1ps
module word_buffer
  import dac_loader_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // filling side
  latch_word_if.snk fill,
  // draining side
  latch_word_if.src drain
);
  localparam int PW = $clog2(DEPTH);
  logic [13:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic do_wr;
  logic do_rd;

  assign do_wr = fill.valid && fill.ready;
  assign do_rd = drain.valid && drain.ready;
  // compare at the counter's own width; a narrower cast would wrap DEPTH to zero
  assign fill.ready = (count != (PW + 1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.code = mem[rd_ptr][13:2];
  assign drain.sel = mem[rd_ptr][1:0];

  always_ff @(posedge aclk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= {fill.code, fill.sel};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end

  property p_no_overfill;
    @(posedge aclk) disable iff (!aresetn)
    !fill.ready |-> count == (PW + 1)'(DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill)
    else $error("buffer refused while not full");
endmodule : word_buffer

// file: design/quad_dac_serial_loader.sv
// Purpose: serial loader and latches of a quad 12-bit converter, AXI4-Lite view
// Assumes: pins come from another domain; link clock far slower than aclk
// Notes: clear and update act three aclk cycles after the pin moves
// What this block does
// - sample serial input on each falling shift clock edge while framed
// - word is 12-bit code, two address bits, two latch-select bits, MSB first
// - shift register top bit drives the serial output for chaining
// - after sixteen bits compare word bits 3:2 to address pins; drop mismatch
// - bits 1:0 pick input latch: 0 A, 1 B, 2 C, 3 D
// - update strobe low loads all converter latches from input latches together
// - clear low forces every converter latch to zero
// - clear leaves input latches untouched so update restores codes
// - top two code bits decode to three segment switches, ten bits to ladder
// - code is plain unsigned binary, zero to 4095/4096 of reference
// - frame strobe low enables shifting; load on sixteenth falling edge
// - mismatched words still pass through to the serial output
//
// Design decisions made here: the AXI4-Lite register port and the register offsets.
`include "dac_loader_regs.svh"
`timescale 1ns/1ps
module quad_dac_serial_loader
  import dac_loader_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial pins
  input wire logic frame_strobe_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic serial_out,
  input wire logic update_strobe_n,
  input wire logic clear_n,
  input wire logic addr_pin_lo,
  input wire logic addr_pin_hi,
  // converter switch drive
  output logic [3:0][11:0] conv_code,
  output logic [3:0][2:0] seg_sw,
  output logic [3:0][9:0] ladder_sw,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // thermometer: each set bit steers a quarter of the reference
  function automatic logic [2:0] seg_decode(input logic [1:0] top);
    seg_decode = 3'((4'h1 << top) - 4'h1);
  endfunction : seg_decode

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == `CTRL_OFFSET) || (a == `STATUS_OFFSET)
      || (a[7:4] == 4'(`INLATCH_BASE >> 4)) || (a[7:4] == 4'(`CONV_BASE >> 4));
  endfunction : is_mapped

  logic [6:0] sync1;
  logic [6:0] sync2;
  logic clk_prev;
  logic fs_n_s;
  logic sclk_s;
  logic serial_in_s;
  logic upd_n_s;
  logic clr_n_s;
  logic [1:0] addr_s;
  logic fall;
  frame_state_t state;
  logic [3:0] bit_cnt;
  word_t shift_reg;
  word_t next_word;
  logic word_done;
  logic match;
  logic pend_valid;
  code_t pend_code;
  latch_sel_t pend_sel;
  logic overrun;
  logic [7:0] accept_cnt;
  logic [7:0] reject_cnt;
  logic [31:0] ctrl;
  code_t inlatch [4];
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic ovr_clear;

  latch_word_if fill_if ();
  latch_word_if drain_if ();

  word_buffer #(.DEPTH(2)) u_buffer (
    .aclk(aclk),
    .aresetn(aresetn),
    .fill(fill_if),
    .drain(drain_if)
  );

  // every pin is asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= 7'h69;
      sync2 <= 7'h69;
      clk_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {addr_pin_hi, addr_pin_lo, clear_n, update_strobe_n, serial_in,
                shift_clock, frame_strobe_n};
      sync2 <= sync1;
      clk_prev <= sync2[1];
    end
  end

  assign fs_n_s = sync2[0];
  assign sclk_s = sync2[1];
  assign serial_in_s = sync2[2];
  assign upd_n_s = sync2[3];
  assign clr_n_s = sync2[4];
  assign addr_s = sync2[6:5];
  assign fall = clk_prev && !sclk_s;
  // msb arrives first, so shifting left lands it at bit 15
  assign next_word = {shift_reg[14:0], serial_in_s};
  assign match = next_word[`ADDR_HI_POS:`ADDR_LO_POS] == addr_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= FRAME_IDLE;
      bit_cnt <= 4'h0;
      word_done <= 1'b0;
    end
    else
    begin
      word_done <= 1'b0;
      unique case (state)
        FRAME_IDLE:
        begin
          bit_cnt <= 4'h0;
          if (!fs_n_s && ctrl[`CTRL_ENABLE_POS])
          begin
            state <= FRAME_SHIFT;
          end
        end
        FRAME_SHIFT:
        begin
          if (fs_n_s)
          begin
            state <= FRAME_IDLE;
          end
          else if (fall)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `LAST_BIT_COUNT)
            begin
              word_done <= 1'b1;
              state <= FRAME_HOLD;
            end
          end
        end
        FRAME_HOLD:
        begin
          if (fs_n_s)
          begin
            state <= FRAME_IDLE;
          end
        end
      endcase
    end
  end

  // shifting continues past sixteen so chained words pass through
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shift_reg <= 16'h0000;
      serial_out <= 1'b0;
    end
    else
    begin
      if (state != FRAME_IDLE && !fs_n_s && fall)
      begin
        shift_reg <= next_word;
      end
      serial_out <= shift_reg[15];
    end
  end

  // word held until the buffer takes it; a second word meanwhile is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_valid <= 1'b0;
      pend_code <= 12'h000;
      pend_sel <= 2'h0;
      accept_cnt <= 8'h00;
      reject_cnt <= 8'h00;
      overrun <= 1'b0;
    end
    else
    begin
      if (fill_if.valid && fill_if.ready)
      begin
        pend_valid <= 1'b0;
      end
      if (ovr_clear)
      begin
        overrun <= 1'b0;
      end
      if (state == FRAME_SHIFT && !fs_n_s && fall && bit_cnt == `LAST_BIT_COUNT)
      begin
        if (!match)
        begin
          reject_cnt <= reject_cnt + 8'h01;
        end
        else if (pend_valid && !fill_if.ready)
        begin
          overrun <= 1'b1;
        end
        else
        begin
          pend_valid <= 1'b1;
          pend_code <= next_word[`CODE_MSB:`CODE_LSB];
          pend_sel <= next_word[`LATCH_SEL_HI_POS:`LATCH_SEL_LO_POS];
          accept_cnt <= accept_cnt + 8'h01;
        end
      end
    end
  end

  assign fill_if.valid = pend_valid;
  assign fill_if.code = pend_code;
  assign fill_if.sel = pend_sel;
  // input latches hold still while an update copies them
  assign drain_if.ready = upd_n_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        inlatch[i] <= 12'h000;
      end
    end
    else if (drain_if.valid && drain_if.ready)
    begin
      inlatch[drain_if.sel] <= drain_if.code;
    end
  end

  // low ten code bits go straight to the ladder as unsigned binary
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      conv_code <= '0;
      seg_sw <= '0;
      ladder_sw <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!clr_n_s)
        begin
          conv_code[i] <= 12'h000;
          seg_sw[i] <= seg_decode(2'h0);
          ladder_sw[i] <= 10'h000;
        end
        else if (!upd_n_s)
        begin
          conv_code[i] <= inlatch[i];
          seg_sw[i] <= seg_decode(inlatch[i][11:10]);
          ladder_sw[i] <= inlatch[i][9:0];
        end
      end
    end
  end

  assign wr_fire = !awready && !wready && !bvalid;
  assign ovr_clear = wr_fire && aw_addr == `STATUS_OFFSET && w_strb[2]
    && w_data[`STATUS_OVERRUN_POS];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      ctrl <= `CTRL_RESET;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        if (aw_addr == `CTRL_OFFSET && w_strb[0])
        begin
          ctrl[`CTRL_ENABLE_POS] <= w_data[`CTRL_ENABLE_POS];
        end
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= is_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      rdata <= 32'h0000_0000;
      if (araddr == `CTRL_OFFSET)
      begin
        rdata <= ctrl;
      end
      else if (araddr == `STATUS_OFFSET)
      begin
        rdata <= {14'h0, state != FRAME_IDLE, overrun, reject_cnt, accept_cnt};
      end
      else if (araddr[7:4] == 4'(`INLATCH_BASE >> 4))
      begin
        rdata <= {20'h00000, inlatch[araddr[3:2]]};
      end
      else if (araddr[7:4] == 4'(`CONV_BASE >> 4))
      begin
        rdata <= {20'h00000, conv_code[araddr[3:2]]};
      end
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  property p_sample;
    @(posedge aclk) disable iff (!aresetn)
    (state != FRAME_IDLE && !fs_n_s && fall) |=> shift_reg == $past(next_word);
  endproperty
  a_sample: assert property (p_sample)
    else $error("serial bit not shifted on falling edge");

  property p_chain_out;
    @(posedge aclk) disable iff (!aresetn)
    (state != FRAME_IDLE && !fs_n_s && fall) |=> ##1 serial_out == $past(next_word[15], 2);
  endproperty
  a_chain_out: assert property (p_chain_out)
    else $error("serial output not following shift register");

  property p_reject;
    @(posedge aclk) disable iff (!aresetn)
    (state == FRAME_SHIFT && !fs_n_s && fall && bit_cnt == 4'hf && !match)
      |=> reject_cnt == $past(reject_cnt) + 8'h01 && $stable(pend_code);
  endproperty
  a_reject: assert property (p_reject)
    else $error("mismatched word was not discarded");

  property p_select;
    @(posedge aclk) disable iff (!aresetn)
    (drain_if.valid && drain_if.ready) |=> inlatch[$past(drain_if.sel)] == $past(drain_if.code);
  endproperty
  a_select: assert property (p_select)
    else $error("word landed in wrong input latch");

  property p_update;
    @(posedge aclk) disable iff (!aresetn)
    (clr_n_s && !upd_n_s) |=> conv_code[0] == $past(inlatch[0])
      && conv_code[3] == $past(inlatch[3]);
  endproperty
  a_update: assert property (p_update)
    else $error("update did not copy input latches");

  property p_clear;
    @(posedge aclk) disable iff (!aresetn)
    !clr_n_s |=> conv_code == '0 && seg_sw == '0 && ladder_sw == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero converter latches");

  property p_clear_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (!clr_n_s && !(drain_if.valid && drain_if.ready)) |=> inlatch[1] == $past(inlatch[1]);
  endproperty
  a_clear_keeps: assert property (p_clear_keeps)
    else $error("clear disturbed an input latch");

  property p_segments;
    @(posedge aclk) disable iff (!aresetn)
    seg_sw[2] == seg_decode(conv_code[2][11:10]) && ladder_sw[2] == conv_code[2][9:0];
  endproperty
  a_segments: assert property (p_segments)
    else $error("switch drive disagrees with converter code");

  property p_sixteenth;
    @(posedge aclk) disable iff (!aresetn)
    $rose(word_done) |-> $past(bit_cnt) == 4'hf && $past(fall);
  endproperty
  a_sixteenth: assert property (p_sixteenth)
    else $error("word completed on wrong edge");
endmodule : quad_dac_serial_loader

// file: bench/host_model.sv
// Purpose: host serial port model that drives frames into the loader
// Assumes: link clock half period of four aclk cycles (400 ns period)
// Notes: link clock idles low between frames; data line is not pulled
`timescale 1ns/1ps
module host_model
  import dac_loader_pkg::*;
(
  // link pins
  input wire logic aclk,
  output logic frame_strobe_n,
  output logic shift_clock,
  output logic serial_in
);
  initial
  begin
    frame_strobe_n = 1'b1;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  // fewer than 16 bits aborts the frame early
  task send(input word_t w, input int nb);
    @(posedge aclk);
    frame_strobe_n <= 1'b0;
    repeat (4) @(posedge aclk);
    for (int i = 15; i > 15 - nb; i--)
    begin
      shift_clock <= 1'b1;
      serial_in <= w[i];
      repeat (4) @(posedge aclk);
      shift_clock <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    frame_strobe_n <= 1'b1;
    // released line: no pull, so show the inverse of the last bit
    serial_in <= ~serial_in;
  endtask : send
endmodule : host_model

// file: bench/quad_dac_serial_loader_tb_top.sv
// Purpose: self-checking bench of the serial loader
// Assumes: host model on the link, bench as AXI4-Lite master
// Notes: device address straps drawn at random from a fixed seed
`include "dac_loader_regs.svh"
`timescale 1ns/1ps
module quad_dac_serial_loader_tb_top
  import dac_loader_pkg::*;
();
  logic aclk, aresetn, update_strobe_n, clear_n, addr_pin_lo, addr_pin_hi;
  logic frame_strobe_n, shift_clock, serial_in, serial_out;
  logic [3:0][11:0] conv_code;
  logic [3:0][2:0] seg_sw;
  logic [3:0][9:0] ladder_sw;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, en;
  logic [1:0] bresp, rresp, r, dev_addr;
  code_t latch [4];
  code_t cw;
  int error_cnt, n_tests, acc, rej;

  host_model host_u (.aclk(aclk), .frame_strobe_n(frame_strobe_n),
    .shift_clock(shift_clock), .serial_in(serial_in));
  quad_dac_serial_loader dut_u (.aclk(aclk), .aresetn(aresetn),
    .frame_strobe_n(frame_strobe_n), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .update_strobe_n(update_strobe_n), .clear_n(clear_n),
    .addr_pin_lo(addr_pin_lo), .addr_pin_hi(addr_pin_hi), .conv_code(conv_code),
    .seg_sw(seg_sw), .ladder_sw(ladder_sw), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  function automatic logic [2:0] seg(input code_t c);
    return (c[11:10] == 2'h3) ? 3'h7 : (c[11:10] == 2'h2) ? 3'h3 : {2'h0, c[10]};
  endfunction : seg

  task print_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task to_fail();
    error_cnt++;
    print_verdict();
  endtask : to_fail

  task axi_write(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end
    while (!bvalid && n < 50);
    if (n == 50) to_fail();
    bready <= 1'b0;
    r = bresp;
  endtask : axi_write

  task axi_read(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    while (!rvalid && n < 50);
    if (n == 50) to_fail();
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : axi_read

  task frame(input code_t c, input logic [1:0] a, input logic [1:0] s, input int nb);
    word_t w;
    w = {c, a, s};
    host_u.send(w, nb);
    if (nb == 16 && en && a == dev_addr)
    begin
      latch[s] = c;
      acc++;
    end
    else if (nb == 16 && en)
      rej++;
    repeat (16) @(posedge aclk);
    if (nb == 16 && en) chk({31'h0, serial_out}, {31'h0, w[15]});
    axi_read(`INLATCH_BASE + {4'h0, s, 2'h0});
    chk(d, {20'h0, latch[s]});
  endtask : frame

  task conv_chk(input logic on);
    code_t e;
    for (int i = 0; i < 4; i++)
    begin
      e = on ? latch[i] : 12'h000;
      chk({20'h0, conv_code[i]}, {20'h0, e});
      chk({29'h0, seg_sw[i]}, {29'h0, seg(e)});
      chk({22'h0, ladder_sw[i]}, {22'h0, e[9:0]});
      axi_read(`CONV_BASE + 8'(4 * i));
      chk(d, {20'h0, e});
    end
  endtask : conv_chk

  task pulse_update();
    update_strobe_n <= 1'b0;
    repeat (6) @(posedge aclk);
    update_strobe_n <= 1'b1;
    repeat (6) @(posedge aclk);
  endtask : pulse_update

  initial
  begin
    void'($urandom(55));
    dev_addr = 2'($urandom);
    {addr_pin_hi, addr_pin_lo} = dev_addr;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
    {update_strobe_n, clear_n, en, aresetn} = 4'he;
    {error_cnt, n_tests, acc, rej} = {32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 4; i++)
      latch[i] = 12'h000;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_read(`CTRL_OFFSET);
    chk(d, `CTRL_RESET);
    chk({31'h0, serial_out}, 32'h0);
    axi_read(8'h40);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    chk(d, 32'h0);
    axi_write(8'h40, 32'h1);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    // every latch first (corner codes in latches 0 and 3), then random select and address
    for (int k = 0; k < 12; k++)
      frame(k == 0 ? 12'hfff : (k == 3 ? 12'h000 : 12'($urandom)),
        k < 4 ? dev_addr : 2'($urandom), k < 4 ? 2'(k) : 2'($urandom), 16);
    frame(~latch[1], ~dev_addr, 2'h1, 16);
    frame(~latch[0], dev_addr, 2'h0, 9);
    axi_write(`CTRL_OFFSET, 32'h0);
    en = 1'b0;
    frame(~latch[2], dev_addr, 2'h2, 16);
    axi_write(`CTRL_OFFSET, 32'h1);
    en = 1'b1;
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    axi_read(`STATUS_OFFSET);
    chk(d, {16'h0, 8'(rej), 8'(acc)});
    conv_chk(1'b0);
    pulse_update();
    conv_chk(1'b1);
    clear_n <= 1'b0;
    repeat (6) @(posedge aclk);
    conv_chk(1'b0);
    clear_n <= 1'b1;
    frame(latch[3], dev_addr, 2'h3, 16);
    pulse_update();
    conv_chk(1'b1);
    // update held low stalls the buffer: two words wait, one pends, the fourth is lost
    update_strobe_n <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      cw = 12'($urandom);
      host_u.send({cw, dev_addr, 2'(k)}, 16);
      if (k < 3)
      begin
        latch[k] = cw;
        acc++;
      end
      repeat (4) @(posedge aclk);
    end
    axi_read(`STATUS_OFFSET);
    chk(d, {15'h0, 1'b1, 8'(rej), 8'(acc)});
    axi_write(`STATUS_OFFSET, 32'h0001_0000);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
    axi_read(`STATUS_OFFSET);
    chk(d, {16'h0, 8'(rej), 8'(acc)});
    update_strobe_n <= 1'b1;
    repeat (16) @(posedge aclk);
    for (int i = 0; i < 4; i++)
    begin
      axi_read(`INLATCH_BASE + 8'(4 * i));
      chk(d, {20'h0, latch[i]});
    end
    print_verdict();
  end
endmodule : quad_dac_serial_loader_tb_top
